/* dv/drmcb_plc.sv */
// plc model: writes and reads the command registers one word at a time
// assumes the block takes a write on the rising edge; signals change at the falling edge
`timescale 1ns/1ps
module drmcb_plc (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic we_o,
  output logic [8:0] addr_o,
  output logic [15:0] wdata_o
);
  initial begin
    we_o = 1'b0;
    addr_o = 9'h000;
    wdata_o = 16'h0000;
  end
  // callers keep accel in 30..10000 except for zero writes, and decel in 0..10000
  // tracking words are written just before the downstream status
  task automatic write(input logic [8:0] a, input logic [15:0] d);
    @(negedge clk_i);
    we_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    we_o = 1'b0;
    // released data must not keep showing the last word
    wdata_o = ~d;
  endtask
  task automatic read(input logic [8:0] a, output logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    #1 d = rdata_i;
  endtask
endmodule

/* dv/tb.sv */
// testbench for the dual roller motor command block
// assumes the plc model drives the register port; levels checked two edges after a write
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic we, l_en = 1'b0, r_en = 1'b0, geared = 1'b0;
  logic [8:0] addr;
  logic [15:0] wdata, rdata, rd;
  logic l_run, l_dir, r_run, r_dir, spd_u, rmp_u, dn_wake, dn_dep, up_hold, up_rel;
  logic [2:0] l_brake, r_brake;
  logic [15:0] l_spd, l_acc, l_dec, r_spd, r_acc, r_dec, trk1, trk2;
  logic [15:0] want;
  int errors = 0;
  int samples_checked = 0;
  function automatic logic [8:0] hold_off(input int i);
    case (i)
      0: hold_off = drmcb_pkg::OFF_L_SPEED;
      1: hold_off = drmcb_pkg::OFF_L_ACCEL;
      2: hold_off = drmcb_pkg::OFF_L_DECEL;
      3: hold_off = drmcb_pkg::OFF_R_SPEED;
      4: hold_off = drmcb_pkg::OFF_R_ACCEL;
      default: hold_off = drmcb_pkg::OFF_R_DECEL;
    endcase
  endfunction
  function automatic logic [15:0] hold_out(input int i);
    case (i)
      0: hold_out = l_spd;
      1: hold_out = l_acc;
      2: hold_out = l_dec;
      3: hold_out = r_spd;
      4: hold_out = r_acc;
      default: hold_out = r_dec;
    endcase
  endfunction
  // accel values stay in 30..10000, decel in 0..10000
  function automatic logic [15:0] hold_val(input int i);
    case (i)
      0: hold_val = 16'h01f4;
      1: hold_val = 16'h001e;
      2: hold_val = 16'h2710;
      3: hold_val = 16'h0320;
      4: hold_val = 16'h2710;
      default: hold_val = 16'h0000;
    endcase
  endfunction
  always #25 clk = ~clk;
  drmcb_plc i_drmcb_plc (.clk_i(clk), .rdata_i(rdata), .we_o(we), .addr_o(addr),
    .wdata_o(wdata));
  drmcb_top i_drmcb_top (.SYS_CLK_I(clk), .RSTN_I(rstn), .REG_WE_I(we), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .L_PORT_DOUT_EN_I(l_en),
    .R_PORT_DOUT_EN_I(r_en), .GEARED_DRIVE_MOTOR_I(geared), .L_RUN_O(l_run),
    .L_DIR_O(l_dir), .L_BRAKE_O(l_brake), .L_SPEED_O(l_spd), .L_ACCEL_O(l_acc),
    .L_DECEL_O(l_dec), .R_RUN_O(r_run), .R_DIR_O(r_dir), .R_BRAKE_O(r_brake),
    .R_SPEED_O(r_spd), .R_ACCEL_O(r_acc), .R_DECEL_O(r_dec), .SPEED_UNIT_RPM10_O(spd_u),
    .RAMP_UNIT_PULSES_O(rmp_u), .DN_WAKE_O(dn_wake), .DN_DEPART_O(dn_dep),
    .DN_TRACK1_O(trk1), .DN_TRACK2_O(trk2), .UP_HOLD_O(up_hold), .UP_RELEASE_O(up_rel));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    i_drmcb_plc.write(a, d);
    // derived outputs land one edge after the register; allow two
    repeat (2) @(negedge clk);
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [15:0] exp);
    i_drmcb_plc.read(a, rd);
    chk(rd, exp);
  endtask
  task automatic wrap_up;
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #250000;
    errors++;
    wrap_up;
  end
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    rdchk(drmcb_pkg::OFF_L_RUN, 16'h0000);
    rdchk(drmcb_pkg::OFF_R_RUN, 16'h0000);
    chk({l_run, r_run}, 16'h0000);
    chk(16'(r_brake), 16'h0001);
    rdchk(drmcb_pkg::OFF_R_FOLLOW, 16'h0001);
    wr(drmcb_pkg::OFF_L_RUN, 16'h0101);
    chk({l_run, l_dir}, 16'h0003);
    wr(drmcb_pkg::OFF_L_RUN, 16'h0001);
    chk({l_run, l_dir}, 16'h0002);
    for (int i = 1; i <= 4; i++) begin
      wr(drmcb_pkg::OFF_L_BRAKE, 16'(i));
      chk(16'(l_brake), 16'(i));
    end
    wr(drmcb_pkg::OFF_L_BRAKE, 16'h0000);
    chk(16'(l_brake), 16'h0004);
    rdchk(drmcb_pkg::OFF_L_BRAKE, 16'h0004);
    wr(drmcb_pkg::OFF_R_BRAKE, 16'h0003);
    chk(16'(r_brake), 16'h0003);
    wr(drmcb_pkg::OFF_R_BRAKE, 16'h0000);
    chk(16'(r_brake), 16'h0003);
    wr(drmcb_pkg::OFF_L_RUN, 16'h0101);
    wr(drmcb_pkg::OFF_R_FOLLOW, 16'h0002);
    chk({r_run, r_dir}, 16'h0003);
    wr(drmcb_pkg::OFF_R_FOLLOW, 16'h0003);
    chk({r_run, r_dir}, 16'h0002);
    wr(drmcb_pkg::OFF_R_FOLLOW, 16'h0000);
    chk({r_run, r_dir}, 16'h0002);
    wr(drmcb_pkg::OFF_R_FOLLOW, 16'h0001);
    chk({r_run, r_dir}, 16'h0000);
    // right runs forward while left's own word asks reverse, so mirroring shows
    wr(drmcb_pkg::OFF_R_RUN, 16'h0001);
    wr(drmcb_pkg::OFF_L_FOLLOW, 16'h0002);
    chk({l_run, l_dir}, 16'h0002);
    wr(drmcb_pkg::OFF_L_FOLLOW, 16'h0001);
    chk({l_run, l_dir}, 16'h0003);
    r_en = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(r_run), 16'h0000);
    r_en = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(r_run), 16'h0001);
    l_en = 1'b1;
    repeat (2) @(negedge clk);
    chk(16'(l_run), 16'h0000);
    l_en = 1'b0;
    for (int i = 0; i < 6; i++) begin
      want = hold_val(i);
      wr(hold_off(i), 16'h0040 + 16'(i));
      wr(hold_off(i), want);
      wr(hold_off(i), 16'h0000);
      if (want == 16'h0000) begin
        want = 16'h0040 + 16'(i);
      end
      chk(hold_out(i), want);
      rdchk(hold_off(i), want);
    end
    for (int g = 1; g >= 0; g--) begin
      geared = g[0];
      repeat (2) @(negedge clk);
      chk({spd_u, rmp_u}, {14'h0000, g[0], g[0]});
    end
    wr(drmcb_pkg::OFF_DN_STATUS, drmcb_pkg::DN_WAKE);
    chk({dn_wake, dn_dep}, 16'h0002);
    wr(drmcb_pkg::OFF_TRACK1, 16'hbeef);
    wr(drmcb_pkg::OFF_TRACK2, 16'h8001);
    wr(drmcb_pkg::OFF_DN_STATUS, drmcb_pkg::DN_DEPART);
    chk({dn_wake, dn_dep}, 16'h0001);
    chk(trk1, 16'hbeef);
    chk(trk2, 16'h8001);
    wr(drmcb_pkg::OFF_UP_STATUS, drmcb_pkg::UP_HOLD);
    chk({up_hold, up_rel}, 16'h0002);
    wr(drmcb_pkg::OFF_UP_STATUS, drmcb_pkg::UP_RELEASE);
    chk({up_hold, up_rel}, 16'h0001);
    // both motors run here; a reset in mid-run must stop them
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    chk({l_run, r_run}, 16'h0000);
    rdchk(drmcb_pkg::OFF_L_RUN, 16'h0000);
    rdchk(drmcb_pkg::OFF_L_BRAKE, 16'h0001);
    wr(9'h1ff, 16'h1234);
    rdchk(9'h1ff, 16'h0000);
    wrap_up;
  end
endmodule

/* rtl/drmcb_channel.sv */
// per-channel command resolution: brake method and effective run/direction
// assumes the other channel's own run and direction are supplied
`timescale 1ns/1ps
module drmcb_channel (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic brake_we_i,
  input wire logic follow_we_i,
  input wire logic [15:0] wdata_i,
  input wire logic own_run_i,
  input wire logic own_dir_i,
  input wire logic other_run_i,
  input wire logic other_dir_i,
  output logic [15:0] brake_o,
  output logic [15:0] follow_o,
  output drmcb_pkg::drmcb_follow_t mode_o,
  output logic run_o,
  output logic dir_o
);
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      brake_o <= drmcb_pkg::BRAKE_RESET;
    end else if (brake_we_i && wdata_i >= 16'(drmcb_pkg::BRAKE_STANDARD)
                 && wdata_i <= 16'(drmcb_pkg::BRAKE_TORQUE)) begin // see [R2] [R3]
      brake_o <= wdata_i;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      follow_o <= 16'h0001;
      mode_o <= drmcb_pkg::DRMCB_FOLLOW_INDEP;
    end else if (follow_we_i) begin
      case (wdata_i)
        16'h0001: begin // see [R4]
          follow_o <= wdata_i;
          mode_o <= drmcb_pkg::DRMCB_FOLLOW_INDEP;
        end
        16'h0002: begin // see [R5]
          follow_o <= wdata_i;
          mode_o <= drmcb_pkg::DRMCB_FOLLOW_MIRROR;
        end
        16'h0003: begin // see [R6]
          follow_o <= wdata_i;
          mode_o <= drmcb_pkg::DRMCB_FOLLOW_OPPOSE;
        end
        default: begin
          // zero and unknown codes leave pairing unchanged; see [R4]
        end
      endcase
    end
  end

  always_comb begin
    case (mode_o)
      drmcb_pkg::DRMCB_FOLLOW_MIRROR: begin
        run_o = other_run_i; // see [R5]
        dir_o = other_dir_i;
      end
      drmcb_pkg::DRMCB_FOLLOW_OPPOSE: begin
        run_o = other_run_i; // see [R6]
        dir_o = !other_dir_i;
      end
      default: begin
        run_o = own_run_i; // see [R4]
        dir_o = own_dir_i;
      end
    endcase
  end
endmodule

/* rtl/drmcb_hold_reg.sv */
// one 16-bit setting that keeps its last non-zero value when zero is written
// assumes a one-cycle write strobe synchronous to the clock
`timescale 1ns/1ps
module drmcb_hold_reg #(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic we_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] value_o
);
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      value_o <= RESET_VALUE;
    end else if (we_i && wdata_i != 16'h0000) begin
      value_o <= wdata_i;
    end
  end
endmodule

/* rtl/drmcb_top.sv */
// What this block does
// [R1] run register bit 0 runs/stops motor; bit 8 reverses configured direction
// [R2] brake codes 1..4: standard, coast, servo, continuous torque
// [R3] writing 0 to brake method keeps the previous method
// [R4] follow mode 0 ignored; 1 makes the channel independent
// [R5] follow mode 2 copies the other channel's run and direction
// [R6] follow mode 3 follows other run, opposite direction
// [R7] speed in mm/s for roller motor, rpm times ten for geared motor
// [R8] writing 0 to speed keeps the last non-zero speed
// [R9] ramps in mm for roller motor, motor pulses for geared motor
// [R10] controller writes acceleration 30 to 10000
// [R11] controller writes deceleration 0 to 10000
// [R12] writing 0 to a ramp keeps the last non-zero ramp
// [R13] downstream status 4 wakes the downstream module's first zone
// [R14] downstream status 1 hands off carton; neighbour takes tracking words
// [R15] upstream status 5 makes upstream discharge zone hold cartons
// [R16] upstream status 1 makes upstream discharge zone release cartons
// [R17] controller writes tracking words together with downstream status command
// [R18] tracking words are 16-bit values tied to the discharged carton
// [R19] motor port digital-output enable bit 15 overrides motor control
// [R20] run registers reset to stop
// file holds the top: register file for both channels and neighbour messages
// assumes a synchronous register port with word index addressing
`timescale 1ns/1ps
module drmcb_top (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic REG_WE_I,
  input wire logic [8:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic L_PORT_DOUT_EN_I,
  input wire logic R_PORT_DOUT_EN_I,
  input wire logic GEARED_DRIVE_MOTOR_I,
  output logic L_RUN_O,
  output logic L_DIR_O,
  output logic [2:0] L_BRAKE_O,
  output logic [15:0] L_SPEED_O,
  output logic [15:0] L_ACCEL_O,
  output logic [15:0] L_DECEL_O,
  output logic R_RUN_O,
  output logic R_DIR_O,
  output logic [2:0] R_BRAKE_O,
  output logic [15:0] R_SPEED_O,
  output logic [15:0] R_ACCEL_O,
  output logic [15:0] R_DECEL_O,
  output logic SPEED_UNIT_RPM10_O,
  output logic RAMP_UNIT_PULSES_O,
  output logic DN_WAKE_O,
  output logic DN_DEPART_O,
  output logic [15:0] DN_TRACK1_O,
  output logic [15:0] DN_TRACK2_O,
  output logic UP_HOLD_O,
  output logic UP_RELEASE_O
);
  logic [15:0] l_run;
  logic [15:0] r_run;
  logic [15:0] up_status;
  logic [15:0] dn_status;
  logic [15:0] track1;
  logic [15:0] track2;
  logic [15:0] l_brake;
  logic [15:0] r_brake;
  logic [15:0] l_follow;
  logic [15:0] r_follow;
  logic [15:0] hold_val [6];
  logic l_run_eff;
  logic l_dir_eff;
  logic r_run_eff;
  logic r_dir_eff;

  localparam logic [8:0] HOLD_OFF [6] = '{drmcb_pkg::OFF_L_SPEED, drmcb_pkg::OFF_L_ACCEL,
    drmcb_pkg::OFF_L_DECEL, drmcb_pkg::OFF_R_SPEED, drmcb_pkg::OFF_R_ACCEL,
    drmcb_pkg::OFF_R_DECEL};

  function automatic logic hit(input logic [8:0] off);
    hit = REG_WE_I && (REG_ADDR_I == off);
  endfunction

  // speed and ramp settings all share the keep-last-non-zero behaviour
  for (genvar i = 0; i < 6; i++) begin : g_hold
    drmcb_hold_reg #(
      .RESET_VALUE(i % 3 == 0 ? drmcb_pkg::SPEED_RESET : drmcb_pkg::RAMP_RESET)
    ) u_hold (
      .SYS_CLK_I(SYS_CLK_I),
      .RSTN_I(RSTN_I),
      .we_i(hit(HOLD_OFF[i])), // see [R8] [R12]
      .wdata_i(REG_WDATA_I),
      .value_o(hold_val[i])
    );
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      l_run <= drmcb_pkg::RUN_RESET; // see [R20]
      r_run <= drmcb_pkg::RUN_RESET;
    end else begin
      if (hit(drmcb_pkg::OFF_L_RUN)) begin
        l_run <= REG_WDATA_I;
      end
      if (hit(drmcb_pkg::OFF_R_RUN)) begin
        r_run <= REG_WDATA_I;
      end
    end
  end

  // status words are commands that stand until rewritten; ranges are not
  // checked because the controller owns them
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      up_status <= drmcb_pkg::STATUS_RESET;
      dn_status <= drmcb_pkg::STATUS_RESET;
      track1 <= 16'h0000;
      track2 <= 16'h0000;
    end else begin
      if (hit(drmcb_pkg::OFF_UP_STATUS)) begin
        up_status <= REG_WDATA_I;
      end
      if (hit(drmcb_pkg::OFF_DN_STATUS)) begin
        dn_status <= REG_WDATA_I;
      end
      if (hit(drmcb_pkg::OFF_TRACK1)) begin
        track1 <= REG_WDATA_I; // see [R18]
      end
      if (hit(drmcb_pkg::OFF_TRACK2)) begin
        track2 <= REG_WDATA_I;
      end
    end
  end

  drmcb_channel u_left (
    .SYS_CLK_I(SYS_CLK_I),
    .RSTN_I(RSTN_I),
    .brake_we_i(hit(drmcb_pkg::OFF_L_BRAKE)),
    .follow_we_i(hit(drmcb_pkg::OFF_L_FOLLOW)),
    .wdata_i(REG_WDATA_I),
    .own_run_i(l_run[drmcb_pkg::RUN_BIT]),
    .own_dir_i(l_run[drmcb_pkg::DIR_BIT]),
    .other_run_i(r_run[drmcb_pkg::RUN_BIT]),
    .other_dir_i(r_run[drmcb_pkg::DIR_BIT]),
    .brake_o(l_brake),
    .follow_o(l_follow),
    .mode_o(),
    .run_o(l_run_eff),
    .dir_o(l_dir_eff)
  );

  // followers copy the other channel's own register, so two followers never loop
  drmcb_channel u_right (
    .SYS_CLK_I(SYS_CLK_I),
    .RSTN_I(RSTN_I),
    .brake_we_i(hit(drmcb_pkg::OFF_R_BRAKE)),
    .follow_we_i(hit(drmcb_pkg::OFF_R_FOLLOW)),
    .wdata_i(REG_WDATA_I),
    .own_run_i(r_run[drmcb_pkg::RUN_BIT]),
    .own_dir_i(r_run[drmcb_pkg::DIR_BIT]),
    .other_run_i(l_run[drmcb_pkg::RUN_BIT]),
    .other_dir_i(l_run[drmcb_pkg::DIR_BIT]),
    .brake_o(r_brake),
    .follow_o(r_follow),
    .mode_o(),
    .run_o(r_run_eff),
    .dir_o(r_dir_eff)
  );

  // data outputs registered; a port in digital-output use sees no motor run from the edge after its enable rises
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      L_RUN_O <= 1'b0;
      L_DIR_O <= 1'b0;
      R_RUN_O <= 1'b0;
      R_DIR_O <= 1'b0;
      L_BRAKE_O <= drmcb_pkg::BRAKE_STANDARD;
      R_BRAKE_O <= drmcb_pkg::BRAKE_STANDARD;
    end else begin
      L_RUN_O <= l_run_eff && !L_PORT_DOUT_EN_I; // see [R1] [R19]
      L_DIR_O <= l_dir_eff;
      R_RUN_O <= r_run_eff && !R_PORT_DOUT_EN_I; // see [R1] [R19]
      R_DIR_O <= r_dir_eff;
      L_BRAKE_O <= l_brake[2:0]; // see [R2]
      R_BRAKE_O <= r_brake[2:0];
    end
  end

  assign L_SPEED_O = hold_val[0]; // see [R7]
  assign L_ACCEL_O = hold_val[1]; // see [R9]
  assign L_DECEL_O = hold_val[2];
  assign R_SPEED_O = hold_val[3];
  assign R_ACCEL_O = hold_val[4];
  assign R_DECEL_O = hold_val[5];

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      SPEED_UNIT_RPM10_O <= 1'b0;
      RAMP_UNIT_PULSES_O <= 1'b0;
      DN_WAKE_O <= 1'b0;
      DN_DEPART_O <= 1'b0;
      UP_HOLD_O <= 1'b0;
      UP_RELEASE_O <= 1'b0;
      DN_TRACK1_O <= 16'h0000;
      DN_TRACK2_O <= 16'h0000;
    end else begin
      SPEED_UNIT_RPM10_O <= GEARED_DRIVE_MOTOR_I; // see [R7]
      RAMP_UNIT_PULSES_O <= GEARED_DRIVE_MOTOR_I; // see [R9]
      DN_WAKE_O <= dn_status == drmcb_pkg::DN_WAKE; // see [R13]
      DN_DEPART_O <= dn_status == drmcb_pkg::DN_DEPART; // see [R14]
      UP_HOLD_O <= up_status == drmcb_pkg::UP_HOLD; // see [R15]
      UP_RELEASE_O <= up_status == drmcb_pkg::UP_RELEASE; // see [R16]
      DN_TRACK1_O <= track1; // see [R14] [R17]
      DN_TRACK2_O <= track2;
    end
  end

  always_comb begin
    case (REG_ADDR_I)
      drmcb_pkg::OFF_L_SPEED: REG_RDATA_O = hold_val[0];
      drmcb_pkg::OFF_L_ACCEL: REG_RDATA_O = hold_val[1];
      drmcb_pkg::OFF_L_DECEL: REG_RDATA_O = hold_val[2];
      drmcb_pkg::OFF_R_SPEED: REG_RDATA_O = hold_val[3];
      drmcb_pkg::OFF_R_ACCEL: REG_RDATA_O = hold_val[4];
      drmcb_pkg::OFF_R_DECEL: REG_RDATA_O = hold_val[5];
      drmcb_pkg::OFF_UP_STATUS: REG_RDATA_O = up_status;
      drmcb_pkg::OFF_DN_STATUS: REG_RDATA_O = dn_status;
      drmcb_pkg::OFF_TRACK1: REG_RDATA_O = track1;
      drmcb_pkg::OFF_TRACK2: REG_RDATA_O = track2;
      drmcb_pkg::OFF_L_RUN: REG_RDATA_O = l_run;
      drmcb_pkg::OFF_L_BRAKE: REG_RDATA_O = l_brake;
      drmcb_pkg::OFF_L_FOLLOW: REG_RDATA_O = l_follow;
      drmcb_pkg::OFF_R_RUN: REG_RDATA_O = r_run;
      drmcb_pkg::OFF_R_BRAKE: REG_RDATA_O = r_brake;
      drmcb_pkg::OFF_R_FOLLOW: REG_RDATA_O = r_follow;
      default: REG_RDATA_O = 16'h0000;
    endcase
  end

  property p_run_follows;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      !L_PORT_DOUT_EN_I |=> (L_RUN_O == $past(l_run_eff));
  endproperty
  a_run_follows: assert property (p_run_follows) else $error("left run mismatch"); // see [R1]

  property p_dout_blocks;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I) R_PORT_DOUT_EN_I |=> !R_RUN_O;
  endproperty
  a_dout_blocks: assert property (p_dout_blocks) else $error("right runs in dout use"); // see [R19]

  property p_brake_zero_keeps;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      hit(drmcb_pkg::OFF_L_BRAKE) && REG_WDATA_I == 16'h0000 |=> $stable(l_brake);
  endproperty
  a_brake_zero_keeps: assert property (p_brake_zero_keeps) else $error("brake lost"); // see [R3]

  property p_brake_write;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      hit(drmcb_pkg::OFF_R_BRAKE) && REG_WDATA_I == 16'h0003 |=> ##1 R_BRAKE_O == 3'h3;
  endproperty
  a_brake_write: assert property (p_brake_write) else $error("brake not taken"); // see [R2]

  property p_speed_zero_keeps;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      hit(drmcb_pkg::OFF_L_SPEED) && REG_WDATA_I == 16'h0000 |=> $stable(L_SPEED_O);
  endproperty
  a_speed_zero_keeps: assert property (p_speed_zero_keeps) else $error("speed lost"); // see [R8]

  property p_ramp_write;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      hit(drmcb_pkg::OFF_R_DECEL) && REG_WDATA_I != 16'h0000
        |=> R_DECEL_O == $past(REG_WDATA_I);
  endproperty
  a_ramp_write: assert property (p_ramp_write) else $error("ramp not taken"); // see [R12]

  // checked at the registered pins, so a broken follow path cannot hide in the mux
  property p_mirror;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      l_follow == 16'h0002 && !L_PORT_DOUT_EN_I
        |=> L_RUN_O == $past(r_run[drmcb_pkg::RUN_BIT])
          && L_DIR_O == $past(r_run[drmcb_pkg::DIR_BIT]);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror broken"); // see [R5]

  property p_oppose;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      r_follow == 16'h0003 && !R_PORT_DOUT_EN_I
        |=> R_RUN_O == $past(l_run[drmcb_pkg::RUN_BIT])
          && R_DIR_O != $past(l_run[drmcb_pkg::DIR_BIT]);
  endproperty
  a_oppose: assert property (p_oppose) else $error("oppose broken"); // see [R6]

  sequence s_wake_write;
    hit(drmcb_pkg::OFF_DN_STATUS) && REG_WDATA_I == drmcb_pkg::DN_WAKE;
  endsequence
  property p_wake;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I) s_wake_write |=> ##1 DN_WAKE_O && !DN_DEPART_O;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missing"); // see [R13]

  property p_hold;
    @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      hit(drmcb_pkg::OFF_UP_STATUS) && REG_WDATA_I == drmcb_pkg::UP_HOLD |=> ##1 UP_HOLD_O;
  endproperty
  a_hold: assert property (p_hold) else $error("hold missing"); // see [R15]
endmodule

/* shared/drmcb_pkg.sv */
// package for the dual roller motor command block: register map, fields, codes
// assumes registers are reached by a plain synchronous word-write/read port
package drmcb_pkg;
  localparam logic [8:0] OFF_L_SPEED = 9'h028;
  localparam logic [8:0] OFF_L_ACCEL = 9'h02b;
  localparam logic [8:0] OFF_L_DECEL = 9'h02c;
  localparam logic [8:0] OFF_R_SPEED = 9'h040;
  localparam logic [8:0] OFF_R_ACCEL = 9'h043;
  localparam logic [8:0] OFF_R_DECEL = 9'h044;
  localparam logic [8:0] OFF_UP_STATUS = 9'h074;
  localparam logic [8:0] OFF_DN_STATUS = 9'h0c4;
  localparam logic [8:0] OFF_TRACK1 = 9'h0c9;
  localparam logic [8:0] OFF_TRACK2 = 9'h0ca;
  localparam logic [8:0] OFF_L_RUN = 9'h104;
  localparam logic [8:0] OFF_L_BRAKE = 9'h105;
  localparam logic [8:0] OFF_L_FOLLOW = 9'h106;
  localparam logic [8:0] OFF_R_RUN = 9'h10e;
  localparam logic [8:0] OFF_R_BRAKE = 9'h10f;
  localparam logic [8:0] OFF_R_FOLLOW = 9'h110;
  localparam int RUN_BIT = 0;
  localparam int DIR_BIT = 8;
  localparam logic [15:0] RUN_RESET = 16'h0000;
  localparam logic [15:0] BRAKE_RESET = 16'h0001;
  localparam logic [15:0] SPEED_RESET = 16'h0000;
  localparam logic [15:0] RAMP_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [2:0] BRAKE_STANDARD = 3'h1;
  localparam logic [2:0] BRAKE_COAST = 3'h2;
  localparam logic [2:0] BRAKE_SERVO = 3'h3;
  localparam logic [2:0] BRAKE_TORQUE = 3'h4;
  localparam logic [15:0] DN_WAKE = 16'h0004;
  localparam logic [15:0] DN_DEPART = 16'h0001;
  localparam logic [15:0] UP_HOLD = 16'h0005;
  localparam logic [15:0] UP_RELEASE = 16'h0001;
  typedef enum logic [1:0] {
    DRMCB_FOLLOW_INDEP = 2'b00,
    DRMCB_FOLLOW_MIRROR = 2'b01,
    DRMCB_FOLLOW_OPPOSE = 2'b11
  } drmcb_follow_t;
endpackage
